// file: hdl/irqx_top.sv
// Interrupt expander: grouped sources, vector RAM, external edges, AHB-Lite slave
`timescale 1ns/100ps
`include "irqx_consts.svh"
module irqx_top
  import irqx_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Peripheral sources, same clock
  input  wire logic [95:0] src_irq,
  // External pins, asynchronous
  input  wire logic        first_external_request,
  input  wire logic        second_external_request,
  input  wire logic        shared_nonmaskable_request_input,
  // Processor side
  output logic [11:0]      processor_irq_line,
  input  wire logic        svc_req,
  input  wire logic [3:0]  svc_line,
  output logic             svc_busy,
  output logic             vec_valid,
  output logic             vec_hit,
  output logic [6:0]       vec_src,
  output logic [31:0]      vec_data,
  output logic [2:0]       ext_irq_pulse,
  output logic             external_nonmaskable_request,
  // Summary interrupt
  output logic             irq
);

  // Bus address phase capture
  logic        wr_q;            // Write data phase pending
  logic        rd_q;            // Read data phase pending
  logic [11:0] addr_q;          // Captured byte address
  // Block state
  irqx_word_t  vec_ram [96];    // Vector per source
  logic [95:0] en_q;            // Per-source enables
  logic [95:0] pend_q;          // Pending sources
  logic [95:0] pend_d;
  logic [7:0]  xctl_q;          // External enables and polarities
  irqx_cnt_t   cnt_q [3];       // Time-stamp counters
  logic [2:0]  s1_q;            // First synchroniser stage
  logic [2:0]  s2_q;            // Second synchroniser stage
  logic [2:0]  s3_q;            // Previous synchronised level
  logic [4:0]  sts_q;           // Sticky event status
  logic [4:0]  msk_q;           // Interrupt mask
  irqx_state_t state_q;         // Service sequence
  logic [2:0]  scnt_q;          // Cycles into the service sequence
  logic [3:0]  grp_q;           // Group being serviced
  logic        valid_q;
  logic        hit_q;
  logic [6:0]  src_q;
  irqx_word_t  data_q;
  logic [2:0]  xpulse_q;
  logic        nmi_q;

  // Address phase is taken when selected, active and the bus is ready
  wire         take    = hsel & htrans[1] & hready;
  wire         vec_sel = addr_q < `IRQX_A_VEC_LIM;
  wire [6:0]   vec_idx = addr_q[8:2];
  wire         en_sel  = addr_q >= `IRQX_A_EN0 && addr_q <= `IRQX_A_EN2;
  wire         pnd_sel = addr_q >= `IRQX_A_PND0 && addr_q <= `IRQX_A_PND2;
  wire         cnt_sel = addr_q >= `IRQX_A_CNT0 && addr_q <= `IRQX_A_CNT2;
  wire [1:0]   wsel    = addr_q[3:2];
  wire [1:0]   csel    = addr_q[3:2] - 2'h1;
  wire         vram_we = wr_q & vec_sel;
  wire         xctl_we = wr_q & (addr_q == `IRQX_A_XCTL);
  wire         ists_we = wr_q & (addr_q == `IRQX_A_ISTS);
  wire         imsk_we = wr_q & (addr_q == `IRQX_A_IMSK);

  // Zero-wait slave, always OKAY; reads come straight from flops
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = !rd_q ? `IRQX_RST_W :
                     vec_sel ? vec_ram[vec_idx] :
                     en_sel  ? en_q[32*wsel +: 32] :
                     pnd_sel ? pend_q[32*wsel +: 32] :
                     (addr_q == `IRQX_A_XCTL) ? {24'h0, xctl_q} :
                     cnt_sel ? {16'h0, cnt_q[csel]} :
                     (addr_q == `IRQX_A_ISTS) ? {27'h0, sts_q} :
                     (addr_q == `IRQX_A_IMSK) ? {27'h0, msk_q} : `IRQX_RST_W;

  // Capture address phase; only word accesses are issued by the master
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      addr_q <= 12'h000;
    end else begin
      wr_q   <= take & hwrite;
      rd_q   <= take & ~hwrite;
      addr_q <= take ? haddr[11:0] : addr_q;
    end
  end

  // Vector RAM, writable at any time, even during a fetch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < `IRQX_NSRC; i++) vec_ram[i] <= `IRQX_RST_W;
    end else if (vram_we) begin
      vec_ram[vec_idx] <= hwdata;  // [RULE3]
    end
  end

  // Service sequence: group taken with the request, source picked when the vector is handed over
  wire         idle    = state_q == IRQX_IDLE;
  wire         fin     = !idle && scnt_q == 3'(`IRQX_SAVE_LAST);
  wire [7:0]   gmask   = pend_q[grp_q*`IRQX_GSIZE +: `IRQX_GSIZE] & en_q[grp_q*`IRQX_GSIZE +: `IRQX_GSIZE];
  wire         ghit    = |gmask;
  wire [2:0]   gpick   = lowest(gmask);
  wire [6:0]   pick    = {grp_q, gpick};
  wire [95:0]  clr     = (fin & ghit) ? (96'h1 << pick) : 96'h0;

  // Lowest set member wins inside a group
  function automatic logic [2:0] lowest(input logic [7:0] m);
    logic [2:0] r;
    r = 3'h0;
    for (int b = 7; b >= 0; b--) if (m[b]) r = 3'(b);
    return r;
  endfunction : lowest

  // Sources latch until acknowledged; a new request beats the clear
  assign pend_d = (pend_q & ~clr) | src_irq;  // [RULE1] [RULE12]

  // Per-source enables and pending, one group per processor line
  generate
    for (genvar g = 0; g < `IRQX_NGRP; g++) begin : g_grp
      assign processor_irq_line[g] =
        |(pend_q[g*`IRQX_GSIZE +: `IRQX_GSIZE] & en_q[g*`IRQX_GSIZE +: `IRQX_GSIZE]);  // [RULE2] [RULE5] [RULE12]
    end
    for (genvar w = 0; w < 3; w++) begin : g_en
      // Enable words written by software
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) en_q[32*w +: 32] <= `IRQX_RST_W;
        else if (wr_q && en_sel && wsel == 2'(w)) en_q[32*w +: 32] <= hwdata;  // [RULE5]
      end
    end
  endgenerate

  // Pending register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) pend_q <= 96'h0;
    else pend_q <= pend_d;
  end

  // Fetch and save take a fixed eight cycles; requests while busy are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= IRQX_IDLE;
      scnt_q  <= 3'h0;
      grp_q   <= 4'h0;
      valid_q <= 1'b0;
      hit_q   <= 1'b0;
      src_q   <= 7'h00;
      data_q  <= `IRQX_RST_W;
    end else begin
      valid_q <= fin;
      case (state_q)
        IRQX_IDLE: begin
          scnt_q <= 3'h0;
          if (svc_req) begin
            state_q <= IRQX_FETCH;
            grp_q   <= svc_line < 4'(`IRQX_NGRP) ? svc_line : 4'h0;
          end
        end
        default: begin
          scnt_q <= scnt_q + 3'h1;
          if (fin) begin
            state_q <= IRQX_IDLE;  // [RULE4]
            hit_q   <= ghit;
            src_q   <= pick;
            data_q  <= ghit ? vec_ram[pick] : `IRQX_RST_W;
          end
        end
      endcase
    end
  end

  assign svc_busy  = !idle;
  assign vec_valid = valid_q;
  assign vec_hit   = hit_q;
  assign vec_src   = src_q;
  assign vec_data  = data_q;

  // Pin synchronisers; the shared pin feeds both third maskable and non-maskable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
    end else begin
      s1_q <= {shared_nonmaskable_request_input, second_external_request, first_external_request};  // [RULE6] [RULE7]
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  wire [2:0] rise  = s2_q & ~s3_q;
  wire [2:0] fall  = ~s2_q & s3_q;
  wire [3:0] xen   = xctl_q[`IRQX_XC_EN];
  wire [3:0] xpol  = xctl_q[`IRQX_XC_POL];
  // Polarity 1 selects rising, 0 falling; disabled inputs raise nothing
  wire [2:0] xedge = xen[2:0] & ((xpol[2:0] & rise) | (~xpol[2:0] & fall));  // [RULE8] [RULE9]
  wire       nedge = xen[`IRQX_XC_NMI] & (xpol[`IRQX_XC_NMI] ? rise[2] : fall[2]);  // [RULE7] [RULE9]

  // External control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) xctl_q <= `IRQX_RST_X;
    else if (xctl_we) xctl_q <= hwdata[7:0];
  end

  // Time-stamp counters run freely and restart on an accepted edge
  generate
    for (genvar k = 0; k < `IRQX_NEXT; k++) begin : g_cnt
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) cnt_q[k] <= `IRQX_RST_C;
        else if (xedge[k]) cnt_q[k] <= `IRQX_RST_C;  // [RULE11]
        else cnt_q[k] <= cnt_q[k] + 16'h0001;        // [RULE10]
      end
    end
  endgenerate

  // Request pulses toward the processor
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xpulse_q <= 3'h0;
      nmi_q    <= 1'b0;
    end else begin
      xpulse_q <= xedge;  // [RULE6]
      nmi_q    <= nedge;
    end
  end

  assign ext_irq_pulse                = xpulse_q;
  assign external_nonmaskable_request = nmi_q;

  // Sticky status, write one to clear; a new event beats the clear
  wire [4:0] sts_set = {fin & ghit, nedge, xedge};
  wire [4:0] sts_clr = ists_we ? hwdata[4:0] : 5'h00;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sts_q <= 5'h00;
      msk_q <= 5'h00;
    end else begin
      sts_q <= (sts_q & ~sts_clr) | sts_set;
      msk_q <= imsk_we ? hwdata[4:0] : msk_q;
    end
  end

  assign irq = |(sts_q & msk_q);

  // Checks
  property p_src_to_line;
    @(posedge hclk) disable iff (!hresetn) src_irq[0] && en_q[0] |=> processor_irq_line[0];
  endproperty
  a_src_to_line: assert property (p_src_to_line) else $error("enabled source did not reach line");  // [RULE2]

  property p_disabled_quiet;
    @(posedge hclk) disable iff (!hresetn) (pend_q[15:8] & en_q[15:8]) == 8'h00 |-> !processor_irq_line[1];
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("line high without enabled pending");  // [RULE5]

  property p_fetch_len;
    @(posedge hclk) disable iff (!hresetn) svc_req && idle |=> !vec_valid [*7] ##1 vec_valid;
  endproperty
  a_fetch_len: assert property (p_fetch_len) else $error("vector not handed over in eight cycles");  // [RULE4]

  property p_pend_hold;
    @(posedge hclk) disable iff (!hresetn) pend_q[9] && !(fin && ghit && pick == 7'd9) |=> pend_q[9];
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending lost before acknowledge");  // [RULE12]

  property p_ram_write;
    @(posedge hclk) disable iff (!hresetn) vram_we |=> vec_ram[$past(vec_idx)] == $past(hwdata);
  endproperty
  a_ram_write: assert property (p_ram_write) else $error("vector write not stored");  // [RULE3]

  property p_cnt_clear;
    @(posedge hclk) disable iff (!hresetn) xedge[1] |=> cnt_q[1] == 16'h0000 ##1 cnt_q[1] == 16'h0001;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("counter not cleared on edge");  // [RULE11]

  property p_cnt_run;
    @(posedge hclk) disable iff (!hresetn) !xedge[0] |=> cnt_q[0] == 16'($past(cnt_q[0]) + 16'h0001);
  endproperty
  a_cnt_run: assert property (p_cnt_run) else $error("counter did not advance");  // [RULE10]

  property p_nmi_gate;
    @(posedge hclk) disable iff (!hresetn) !xen[`IRQX_XC_NMI] |=> !external_nonmaskable_request;
  endproperty
  a_nmi_gate: assert property (p_nmi_gate) else $error("disabled non-maskable raised request");  // [RULE9]

  property p_rise_sel;
    @(posedge hclk) disable iff (!hresetn)
      xen[0] && xpol[0] && $rose(first_external_request) |-> ##[1:4] ext_irq_pulse[0];
  endproperty
  a_rise_sel: assert property (p_rise_sel) else $error("rising edge not detected");  // [RULE8]

  property p_shared;
    @(posedge hclk) disable iff (!hresetn)
      xen[2] && xen[3] && xpol[2] == xpol[3] && xedge[2] |=> external_nonmaskable_request && ext_irq_pulse[2];
  endproperty
  a_shared: assert property (p_shared) else $error("shared pin did not drive both requests");  // [RULE7]

  property p_busy_len;
    @(posedge hclk) disable iff (!hresetn) svc_req && idle |=> svc_busy [*7] ##1 !svc_busy;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("service sequence length wrong");  // [RULE4]

  // Handover checks read the RAM and pick as they stood at the deciding edge
  property p_vec_data;
    @(posedge hclk) disable iff (!hresetn) fin && ghit |=> vec_data == $past(vec_ram[pick]) && vec_src == $past(pick);
  endproperty
  a_vec_data: assert property (p_vec_data) else $error("wrong vector handed over");  // [RULE4]

  property p_miss_data;
    @(posedge hclk) disable iff (!hresetn) fin && !ghit |=> !vec_hit && vec_data == `IRQX_RST_W;
  endproperty
  a_miss_data: assert property (p_miss_data) else $error("vector handed over without enabled pending");  // [RULE5]

  property p_sts_set;
    @(posedge hclk) disable iff (!hresetn) xedge[0] |=> sts_q[0];
  endproperty
  a_sts_set: assert property (p_sts_set) else $error("accepted edge not recorded in status");  // [RULE6]

  // Main scenarios
  c_hit:    cover property (@(posedge hclk) disable iff (!hresetn) vec_valid && vec_hit);
  c_nmi:    cover property (@(posedge hclk) disable iff (!hresetn) external_nonmaskable_request);
  c_edge:   cover property (@(posedge hclk) disable iff (!hresetn) ext_irq_pulse[1]);
  c_irq:    cover property (@(posedge hclk) disable iff (!hresetn) irq);
  c_shared: cover property (@(posedge hclk) disable iff (!hresetn) external_nonmaskable_request && ext_irq_pulse[2]);

endmodule : irqx_top

// file: hdl/irqx_consts.svh
// Constants of the interrupt expander: map, field positions, counts, reset values
// Function
// [RULE1] Accept up to 96 peripheral interrupt sources
// [RULE2] Eight sources per group, twelve processor lines
// [RULE3] Per-source vector in software-writable RAM
// [RULE4] Supply vector on service; eight cycles total
// [RULE5] Per-source enable blocks forwarding to line
// [RULE6] Three maskable external interrupt inputs
// [RULE7] Third maskable shares pin with non-maskable
// [RULE8] Rising or falling edge selectable per input
// [RULE9] Per-input enable, non-maskable included
// [RULE10] Free-running 16-bit time-stamp counter per input
// [RULE11] Counter cleared on valid selected edge
// [RULE12] Pending latched until acknowledged; OR per group
`ifndef IRQX_CONSTS_SVH
`define IRQX_CONSTS_SVH
`define IRQX_NSRC      96
`define IRQX_NGRP      12
`define IRQX_GSIZE     8
`define IRQX_NEXT      3
`define IRQX_SAVE_NS   40
`define IRQX_CLK_NS    5
// Cycle of the service count on which the vector is handed over
`define IRQX_SAVE_LAST (((`IRQX_SAVE_NS + `IRQX_CLK_NS - 1) / `IRQX_CLK_NS) - 2)
// Byte addresses on the register bus
`define IRQX_A_VEC_LIM 12'h180
`define IRQX_A_EN0     12'h200
`define IRQX_A_EN2     12'h208
`define IRQX_A_PND0    12'h210
`define IRQX_A_PND2    12'h218
`define IRQX_A_XCTL    12'h220
`define IRQX_A_CNT0    12'h224
`define IRQX_A_CNT2    12'h22c
`define IRQX_A_ISTS    12'h230
`define IRQX_A_IMSK    12'h234
// External control fields
`define IRQX_XC_EN     3:0
`define IRQX_XC_POL    7:4
`define IRQX_XC_NMI    3
// Status bits: three maskable edges, non-maskable edge, vector handed over
`define IRQX_NSTS      5
`define IRQX_ST_NMI    3
`define IRQX_ST_VEC    4
`define IRQX_RST_W     32'h0000_0000
`define IRQX_RST_C     16'h0000
`define IRQX_RST_X     8'h00
`endif

// file: hdl/irqx_pkg.sv
// Types of the interrupt expander
package irqx_pkg;
  // Service sequence states
  typedef enum logic {
    IRQX_IDLE,
    IRQX_FETCH
  } irqx_state_t;
  typedef logic [31:0] irqx_word_t;  // Bus and vector word
  typedef logic [15:0] irqx_cnt_t;   // Time-stamp counter
endpackage : irqx_pkg

// file: verification/irqx_cpu_model.sv
// Processor-side model: raises service requests and times the vector handover
`timescale 1ns/100ps
module irqx_cpu_model
  import irqx_pkg::*;
(
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Bench commands
  input  wire logic       go,
  input  wire logic [3:0] go_line,
  // Expander side
  input  wire logic       svc_busy,
  input  wire logic       vec_valid,
  output logic            svc_req,
  output logic [3:0]      svc_line,
  // Measured handover latency
  output logic [4:0]      lat
);
  logic [4:0] cnt_q;  // Cycles since the request was taken
  // Request held until taken; counts to the vector handover
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      svc_req  <= 1'b0;
      svc_line <= 4'h0;
      cnt_q    <= 5'h00;
      lat      <= 5'h00;
    end else begin
      if (go) begin
        svc_req  <= 1'b1;
        svc_line <= go_line;
      end else if (svc_req && !svc_busy) begin
        svc_req <= 1'b0;  // Taken at this edge
      end
      if (svc_req && !svc_busy) cnt_q <= 5'h01;
      else if (cnt_q != 5'h00) cnt_q <= cnt_q + 5'h01;
      // Vector fetched; latency latched and count cleared
      if (vec_valid) begin
        lat   <= cnt_q;
        cnt_q <= 5'h00;
      end
    end
  end
endmodule : irqx_cpu_model

// file: verification/tb_top.sv
// Self-checking testbench of the interrupt expander
`timescale 1ns/100ps
module tb_top import irqx_pkg::*; ;
  logic        hclk = 1'b0;     // 200 MHz clock
  logic        hresetn = 1'b0;  // Async reset
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [95:0] src_irq = '0;    // Peripheral requests
  logic [2:0]  pins = 3'h0;     // First, second, shared pin
  logic        go = 1'b0;
  logic [3:0]  go_line = 4'h0;
  wire         hreadyout, hresp, svc_req, svc_busy, vec_valid, vec_hit, nmi, irq;
  wire  [31:0] hrdata, vec_data;
  wire  [11:0] line;
  wire  [6:0]  vec_src;
  wire  [3:0]  svc_line;
  wire  [2:0]  xp;
  wire  [4:0]  lat;
  irqx_word_t  rd;
  int          n_errors = 0;
  int          total_checks = 0;
  int          p_cnt [4] = '{0, 0, 0, 0};  // Pulses seen per external input
  // Rows: address, write data, expected read-back
  logic [31:0] rows [10][3] = '{
    '{32'h000, 32'ha5a5_0001, 32'ha5a5_0001}, '{32'h024, 32'h0000_0909, 32'h0000_0909},
    '{32'h028, 32'h0000_0a0a, 32'h0000_0a0a}, '{32'h17c, 32'h0000_5f5f, 32'h0000_5f5f},
    '{32'h200, 32'hffff_ffff, 32'hffff_ffff}, '{32'h204, 32'hf0f0_f0f0, 32'hf0f0_f0f0},
    '{32'h208, 32'h8000_0000, 32'h8000_0000}, '{32'h234, 32'h0000_001f, 32'h0000_001f},
    '{32'h210, 32'hffff_ffff, 32'h0000_0000}, '{32'h300, 32'hdead_beef, 32'h0000_0000}};

  always #2.5 hclk = ~hclk;

  irqx_top irqx_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .src_irq(src_irq), .first_external_request(pins[0]),
    .second_external_request(pins[1]), .shared_nonmaskable_request_input(pins[2]),
    .processor_irq_line(line), .svc_req(svc_req), .svc_line(svc_line), .svc_busy(svc_busy),
    .vec_valid(vec_valid), .vec_hit(vec_hit), .vec_src(vec_src), .vec_data(vec_data),
    .ext_irq_pulse(xp), .external_nonmaskable_request(nmi), .irq(irq));
  irqx_cpu_model irqx_cpu_model_inst (.hclk(hclk), .hresetn(hresetn), .go(go), .go_line(go_line),
    .svc_busy(svc_busy), .vec_valid(vec_valid), .svc_req(svc_req), .svc_line(svc_line), .lat(lat));

  // Count one-cycle pulses of the external inputs
  always @(posedge hclk) begin
    for (int i = 0; i < 3; i++) if (xp[i] === 1'b1) p_cnt[i]++;
    if (nmi === 1'b1) p_cnt[3]++;
  end

  function automatic logic [31:0] cnts();
    return {p_cnt[3][7:0], p_cnt[2][7:0], p_cnt[1][7:0], p_cnt[0][7:0]};
  endfunction : cnts

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One AHB-Lite single transfer; waits for hready in both phases
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output irqx_word_t r);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic pulse(input int s);
    src_irq <= 96'h1 << s;
    @(posedge hclk);
    src_irq <= '0;
    repeat (2) @(posedge hclk);
  endtask : pulse

  task automatic pin(input int i, input logic v);
    pins[i] <= v;
    repeat (10) @(posedge hclk);
  endtask : pin

  // Service one group and compare the handed-over vector
  task automatic svc(input logic [3:0] g, input logic [6:0] s, input logic h, input logic [31:0] d);
    go      <= 1'b1;
    go_line <= g;
    @(posedge hclk);
    go <= 1'b0;
    @(posedge hclk);
    #1;
    chk({31'h0, svc_busy}, 32'h1);
    do @(posedge hclk); while (vec_valid !== 1'b1);
    #1;
    chk(32'(lat), 32'h8);
    chk({31'h0, svc_busy}, 32'h0);
    chk({31'h0, vec_hit}, {31'h0, h});
    if (h) chk(32'(vec_src), 32'(s));
    chk(vec_data, d);
  endtask : svc

  task automatic print_verdict();
    if (n_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end

  initial begin
    repeat (4) @(posedge hclk);
    chk({17'h0, line, irq, hresp, hreadyout}, 32'h1);
    hresetn <= 1'b1;
    // Register table loop
    for (int i = 0; i < 10; i++) begin
      bus(1'b1, rows[i][0], rows[i][1], rd);
      bus(1'b0, rows[i][0], 32'h0, rd);
      chk(rd, rows[i][2]);
    end
    // Two sources of group 1, lower index second
    pulse(10);
    pulse(9);
    chk(32'(line), 32'h002);
    bus(1'b0, 32'h210, 32'h0, rd);
    chk(rd, 32'h0000_0600);
    pulse(40);
    chk(32'(line), 32'h002);
    bus(1'b0, 32'h214, 32'h0, rd);
    chk(rd, 32'h0000_0100);
    pulse(95);
    chk(32'(line), 32'h802);
    svc(4'h1, 7'd9, 1'b1, 32'h0000_0909);
    chk(32'(line), 32'h802);
    svc(4'h1, 7'd10, 1'b1, 32'h0000_0a0a);
    svc(4'h5, 7'd0, 1'b0, 32'h0);
    svc(4'hb, 7'd95, 1'b1, 32'h0000_5f5f);
    // Out-of-range line number falls back to the first group
    pulse(0);
    svc(4'hc, 7'd0, 1'b1, 32'ha5a5_0001);
    chk(32'(line), 32'h000);
    bus(1'b0, 32'h210, 32'h0, rd);
    chk(rd, 32'h0);
    chk(32'(irq), 32'h1);
    bus(1'b0, 32'h230, 32'h0, rd);
    chk(rd, 32'h0000_0010);
    bus(1'b1, 32'h230, 32'h0000_0010, rd);
    @(posedge hclk);
    chk(32'(irq), 32'h0);
    // External inputs: first rising, second falling, third rising, non-maskable falling
    bus(1'b1, 32'h220, 32'h0000_005f, rd);
    pin(0, 1'b1);
    chk(cnts(), 32'h0000_0001);
    bus(1'b0, 32'h224, 32'h0, rd);
    chk(32'(rd < 32'd20), 32'h1);
    bus(1'b0, 32'h228, 32'h0, rd);
    chk(32'(rd > 32'd20), 32'h1);
    pin(0, 1'b0);
    chk(cnts(), 32'h0000_0001);
    pin(1, 1'b1);
    pin(1, 1'b0);
    chk(cnts(), 32'h0000_0101);
    pin(2, 1'b1);
    chk(cnts(), 32'h0001_0101);
    pin(2, 1'b0);
    chk(cnts(), 32'h0101_0101);
    // Disabled first input: no pulse, counter keeps running
    bus(1'b1, 32'h220, 32'h0000_005e, rd);
    pin(0, 1'b1);
    chk(cnts(), 32'h0101_0101);
    bus(1'b0, 32'h224, 32'h0, rd);
    chk(32'(rd > 32'd20), 32'h1);
    bus(1'b0, 32'h230, 32'h0, rd);
    chk(rd, 32'h0000_000f);
    chk(32'(irq), 32'h1);
    bus(1'b1, 32'h234, 32'h0, rd);
    @(posedge hclk);
    chk(32'(irq), 32'h0);
    // Shared pin with both halves on rising edges
    bus(1'b1, 32'h220, 32'h0000_00cc, rd);
    pin(2, 1'b1);
    chk(cnts(), 32'h0202_0101);
    // Reset in mid-run
    pulse(95);
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    chk({19'h0, line, irq}, 32'h0);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, 32'h200, 32'h0, rd);
    chk(rd, 32'h0);
    print_verdict();
  end
endmodule : tb_top
